// ==== hdl/wwdm_pkg.sv ====
// Constants and types for the window watchdog monitor
package wwdm_pkg;
    localparam int CLK_MHZ        = 100;
    localparam int CYC_OPT0_US    = 10;
    localparam int CYC_OPT1_US    = 100;
    localparam int CYC0_CYCLES    = CYC_OPT0_US * CLK_MHZ;
    localparam int CYC1_CYCLES    = CYC_OPT1_US * CLK_MHZ;
    localparam int SAMPLE_US      = 400;
    localparam int SAMPLE_CYCLES  = SAMPLE_US * CLK_MHZ;
    localparam int LOW_MS         = 600;
    localparam int LOW_TICKS      = LOW_MS * 1000 / CYC_OPT1_US;
    localparam int RST_DELAY_US   = 100;
    localparam int RST_DELAY_CYC  = RST_DELAY_US * CLK_MHZ;
    localparam int WIN_W          = 16;
    localparam int ERR_W          = 8;
    localparam int DIV_W          = 20;
    localparam int RST_W          = 24;
    localparam logic [ERR_W-1:0] ERR_INC = 8'h02;
    localparam logic [ERR_W-1:0] ERR_DEC = 8'h01;
    localparam logic [3:0]       TRIG_PATTERN = 4'hC;

    typedef enum logic [4:0] {
        ST_RESET  = 5'h01,
        ST_LONG   = 5'h02,
        ST_CLOSED = 5'h04,
        ST_OPEN   = 5'h08,
        ST_FAULT  = 5'h10
    } wwdm_state_t;
endpackage

// ==== hdl/wwdm_trig_if.sv ====
// Trigger pulse carrier between pin sampler and window sequencer
`timescale 1ns/1ps
interface wwdm_trig_if;
    logic sampleTick;
    logic trigEvent;
    modport src  (output sampleTick, output trigEvent);
    modport sink (input  sampleTick, input  trigEvent);
endinterface

// ==== hdl/wwdm_pin_sampler.sv ====
// Periodic sampler and falling edge filter for the trigger pin
`timescale 1ns/1ps
module wwdm_pin_sampler
    import wwdm_pkg::*;
#(
    parameter int SAMPLE_CNT = SAMPLE_CYCLES
)(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic triggerInputPin,
    wwdm_trig_if.src  trig
);
    logic        sync1_r;
    logic        sync2_r;
    logic [31:0] sampCnt_r;
    logic [3:0]  samples_r;
    logic        tick_r;
    logic        event_r;
    wire         sampleNow = (sampCnt_r == 32'(SAMPLE_CNT - 1));
    wire  [3:0]  samplesNxt = {samples_r[2:0], sync2_r};
    // Two highs then two lows, judged at the second low
    wire         patternHit = (samplesNxt == TRIG_PATTERN);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1_r   <= 1'b0;
            sync2_r   <= 1'b0;
            sampCnt_r <= 32'h0;
            samples_r <= 4'h0;
            tick_r    <= 1'b0;
            event_r   <= 1'b0;
        end
        else
        begin
            sync1_r   <= triggerInputPin;
            sync2_r   <= sync1_r;
            sampCnt_r <= sampleNow ? 32'h0 : sampCnt_r + 32'h1;
            tick_r    <= sampleNow;
            event_r   <= sampleNow && patternHit;
            if (sampleNow)
                samples_r <= samplesNxt;
        end
    end

    assign trig.sampleTick = tick_r;
    assign trig.trigEvent  = event_r;

    a_trig_pattern: assert property (@(posedge clk) disable iff (!arst_n)
        event_r |-> samples_r == TRIG_PATTERN)
        else $error("trigger without two highs then two lows");
    a_trig_on_sample: assert property (@(posedge clk) disable iff (!arst_n)
        event_r |-> tick_r && $past(sampleNow))
        else $error("trigger outside a sampling point");
    a_rise_ignored: assert property (@(posedge clk) disable iff (!arst_n)
        samples_r[0] |-> !event_r)
        else $error("high sample produced a trigger");
endmodule

// ==== hdl/wwdm_window_watchdog_monitor.sv ====
// Window watchdog sequencer with error counter and reset output control
`timescale 1ns/1ps
module wwdm_window_watchdog_monitor
    import wwdm_pkg::*;
#(
    parameter int CYC0_CNT   = CYC0_CYCLES,
    parameter int CYC1_CNT   = CYC1_CYCLES,
    parameter int SAMPLE_CNT = SAMPLE_CYCLES,
    parameter int RESET_CNT  = RST_DELAY_CYC,
    parameter int LOW_CNT    = LOW_TICKS
)(
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             triggerInputPin,
    input  wire logic             spiTriggerWrite,
    input  wire logic             triggerSourcePin,
    input  wire logic             cycleTimeSelect,
    input  wire logic [WIN_W-1:0] openCycles,
    input  wire logic [WIN_W-1:0] closedCycles,
    input  wire logic [ERR_W-1:0] errorThreshold,
    input  wire logic             configWrite,
    input  wire logic             initTimerExpired,
    output logic                  resetOutputPin,
    output logic                  postRegEnable,
    output logic                  hardResetReq,
    output logic                  interruptReq,
    output logic                  windowValid,
    output logic                  windowInvalid,
    output logic                  initServiced,
    output logic [ERR_W-1:0]      errorCount,
    output wwdm_state_t           windowState
);
    wwdm_trig_if trig ();

    wwdm_pin_sampler #(
        .SAMPLE_CNT (SAMPLE_CNT)
    ) u_sampler (
        .clk             (clk),
        .arst_n          (arst_n),
        .triggerInputPin (triggerInputPin),
        .trig            (trig)
    );

    wwdm_state_t      state_r;
    wwdm_state_t      state_nxt;
    logic [DIV_W-1:0] divCnt_r;
    logic [WIN_W-1:0] winCnt_r;
    logic [RST_W-1:0] rstCnt_r;
    logic [ERR_W-1:0] errCnt_r;
    logic             rotHigh_r;
    logic             postEn_r;
    logic             hardReq_r;
    logic             intr_r;
    logic             valid_r;
    logic             invalid_r;
    logic             serviced_r;
    logic             softDone_r;
    logic             restart;
    logic             validEv;
    logic             invalidEv;
    logic             softEv;
    logic             hardEv;

    // SPI selected while triggerSourcePin is low; pin samples ignored unless it is high
    wire trigger = triggerSourcePin ? trig.trigEvent
                                    : spiTriggerWrite;
    wire [DIV_W-1:0] divLast = cycleTimeSelect ?
        DIV_W'(CYC1_CNT - 1) : DIV_W'(CYC0_CNT - 1);
    // At or past the limit: a cycle-time switch cannot overrun the divider
    wire baseTick = (divCnt_r >= divLast);
    wire [WIN_W-1:0] winLimit =
        (state_r == ST_LONG)   ? WIN_W'(LOW_CNT) :
        (state_r == ST_CLOSED) ? closedCycles : openCycles;
    wire [WIN_W-1:0] winCntInc = winCnt_r + WIN_W'(1);
    wire winDone = baseTick && (winCntInc >= winLimit);
    wire inWindow = (state_r == ST_LONG) || (state_r == ST_OPEN) ||
                    (state_r == ST_CLOSED);
    // Init expiry takes precedence, so a coinciding window end is dropped
    wire initHit = initTimerExpired && !serviced_r && inWindow;
    wire rstDone = (rstCnt_r >= RST_W'(RESET_CNT - 1));

    // Saturating error arithmetic
    wire [ERR_W:0] errSum = {1'b0, errCnt_r} + {1'b0, ERR_INC};
    wire [ERR_W-1:0] errAdd = errSum[ERR_W] ? {ERR_W{1'b1}}
                                            : errSum[ERR_W-1:0];
    wire [ERR_W-1:0] errSub = (errCnt_r != '0) ?
        errCnt_r - ERR_DEC : errCnt_r;
    // Overflow reset does not escalate to the fault state
    wire threshHit = invalidEv && (errorThreshold != '0) &&
                     (errAdd >= errorThreshold);
    wire [ERR_W-1:0] errNxt = threshHit ? '0 :
                              invalidEv ? errAdd :
                              validEv   ? errSub : errCnt_r;

    always_comb
    begin
        state_nxt = state_r;
        restart   = 1'b0;
        validEv   = 1'b0;
        invalidEv = 1'b0;
        softEv    = 1'b0;
        hardEv    = 1'b0;
        if (initHit)
        begin
            softEv = !softDone_r;
            hardEv = softDone_r;
        end
        else
        begin
            case (state_r)
                ST_RESET:
                    if (rstDone)
                    begin
                        state_nxt = ST_LONG;
                        restart   = 1'b1;
                    end
                ST_LONG:
                    if (trigger)
                    begin
                        state_nxt = ST_CLOSED;
                        restart   = 1'b1;
                        validEv   = 1'b1;
                    end
                    else if (configWrite)
                    begin
                        state_nxt = ST_OPEN;
                        restart   = 1'b1;
                    end
                    else if (winDone && softDone_r)
                        hardEv = 1'b1;
                    else if (winDone)
                    begin
                        restart   = 1'b1;
                        invalidEv = 1'b1;
                    end
                ST_OPEN:
                    if (trigger)
                    begin
                        state_nxt = ST_CLOSED;
                        restart   = 1'b1;
                        validEv   = 1'b1;
                    end
                    else if (winDone)
                    begin
                        restart   = 1'b1;
                        invalidEv = 1'b1;
                    end
                    else if (configWrite)
                        restart = 1'b1;
                ST_CLOSED:
                    if (trigger)
                    begin
                        state_nxt = ST_OPEN;
                        restart   = 1'b1;
                        invalidEv = 1'b1;
                    end
                    else if (winDone || configWrite)
                    begin
                        state_nxt = ST_OPEN;
                        restart   = 1'b1;
                    end
                ST_FAULT:
                    state_nxt = ST_FAULT;
                default:
                    state_nxt = ST_FAULT;
            endcase
            if (threshHit)
                softEv = 1'b1;
        end
        if (hardEv)
            state_nxt = ST_FAULT;
        else if (softEv)
            state_nxt = ST_RESET;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r  <= ST_RESET;
            divCnt_r <= '0;
            winCnt_r <= '0;
            rstCnt_r <= '0;
        end
        else
        begin
            state_r  <= state_nxt;
            divCnt_r <= (restart || baseTick) ? '0 : divCnt_r + DIV_W'(1);
            winCnt_r <= restart ? '0 : baseTick ? winCntInc : winCnt_r;
            rstCnt_r <= (state_r == ST_RESET) ? rstCnt_r + RST_W'(1) : '0;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            errCnt_r   <= '0;
            rotHigh_r  <= 1'b0;
            postEn_r   <= 1'b1;
            hardReq_r  <= 1'b0;
            intr_r     <= 1'b0;
            valid_r    <= 1'b0;
            invalid_r  <= 1'b0;
            serviced_r <= 1'b0;
            softDone_r <= 1'b0;
        end
        else
        begin
            errCnt_r   <= errNxt;
            rotHigh_r  <= (state_nxt != ST_RESET) && (state_nxt != ST_FAULT);
            postEn_r   <= postEn_r && !hardEv;
            hardReq_r  <= hardEv;
            intr_r     <= invalidEv;
            valid_r    <= validEv;
            invalid_r  <= invalidEv;
            serviced_r <= (serviced_r || validEv) && !softEv && !hardEv;
            softDone_r <= (softDone_r || (softEv && initHit)) && !validEv;
        end
    end

    assign resetOutputPin = rotHigh_r;
    assign postRegEnable  = postEn_r;
    assign hardResetReq   = hardReq_r;
    assign interruptReq   = intr_r;
    assign windowValid    = valid_r;
    assign windowInvalid  = invalid_r;
    assign initServiced   = serviced_r;
    assign errorCount     = errCnt_r;
    assign windowState    = state_r;

    a_long_after_rst: assert property (@(posedge clk) disable iff (!arst_n)
        (state_r == ST_RESET) && rstDone && !initHit |=>
        state_r == ST_LONG && winCnt_r == '0 && resetOutputPin)
        else $error("reset release did not open a long window");
    a_valid_closes: assert property (@(posedge clk) disable iff (!arst_n)
        (state_r == ST_OPEN || state_r == ST_LONG) && trigger && !initHit
        |=> state_r == ST_CLOSED && windowValid && !interruptReq)
        else $error("valid trigger did not start a closed window");
    a_closed_trig: assert property (@(posedge clk) disable iff (!arst_n)
        (state_r == ST_CLOSED) && trigger && !initHit |=>
        windowInvalid && interruptReq)
        else $error("closed window trigger not flagged invalid");
    a_open_timeout: assert property (@(posedge clk) disable iff (!arst_n)
        (state_r == ST_OPEN) && winDone && !trigger && !initHit |=>
        interruptReq && winCnt_r == '0)
        else $error("silent open window not flagged");
    a_err_plus_two: assert property (@(posedge clk) disable iff (!arst_n)
        invalidEv && !threshHit && (errCnt_r < 8'hF0) |=>
        errorCount == $past(errCnt_r) + ERR_INC)
        else $error("error counter did not rise by two");
    a_err_floor: assert property (@(posedge clk) disable iff (!arst_n)
        validEv && (errCnt_r == '0) |=> errorCount == '0)
        else $error("error counter went below zero");
    a_soft_reset: assert property (@(posedge clk) disable iff (!arst_n)
        initHit && !softDone_r |=> !resetOutputPin && postRegEnable
        ##1 !resetOutputPin)
        else $error("soft reset did not pull reset output low");
    a_hard_fault: assert property (@(posedge clk) disable iff (!arst_n)
        hardEv |=> state_r == ST_FAULT && !postRegEnable
        && hardResetReq && !resetOutputPin)
        else $error("hard reset did not enter fault");
    a_thresh_reset: assert property (@(posedge clk) disable iff (!arst_n)
        threshHit |=> state_r == ST_RESET && errorCount == '0)
        else $error("threshold reached without reset");

    c_valid_cycle: cover property (@(posedge clk) disable iff (!arst_n)
        state_r == ST_CLOSED ##[1:1000] state_r == ST_OPEN
        ##[1:1000] windowValid);
    c_closed_err: cover property (@(posedge clk) disable iff (!arst_n)
        state_r == ST_CLOSED && trigger);
    c_soft_rst: cover property (@(posedge clk) disable iff (!arst_n)
        softEv);
    c_fault: cover property (@(posedge clk) disable iff (!arst_n)
        state_r == ST_FAULT);
endmodule

// ==== bench/wwdm_mcu_model.sv ====
// Behavioural microcontroller driving the watchdog trigger pin and SPI
`timescale 1ns/1ps
module wwdm_mcu_model #(
    parameter int SAMPLE_CNT = 5
)(
    input  wire logic clk,
    output logic      triggerInputPin,
    output logic      spiTriggerWrite
);
    initial
    begin
        triggerInputPin = 1'b0;
        spiTriggerWrite = 1'b0;
    end

    // One-cycle write to the trigger command register
    task automatic spi_write();
        @(negedge clk);
        spiTriggerWrite = 1'b1;
        @(negedge clk);
        spiTriggerWrite = 1'b0;
    endtask

    // Whole sample periods, so the filter sees the level once per sample period held
    task automatic pin_hold(input logic lvl, input int samples);
        @(negedge clk);
        triggerInputPin = lvl;
        repeat (samples * SAMPLE_CNT) @(negedge clk);
    endtask

    task automatic pin_set(input logic lvl);
        @(negedge clk);
        triggerInputPin = lvl;
    endtask
endmodule

// ==== bench/test_wwdm_window_watchdog_monitor.sv ====
// Self-checking bench for the window watchdog monitor
`timescale 1ns/1ps
module test_wwdm_window_watchdog_monitor
    import wwdm_pkg::*;
;
    localparam int SMP  = 5;
    localparam int C0   = 4;
    localparam int C1   = 8;
    localparam int RCNT = 6;
    localparam int LCNT = 20;
    logic             clk;
    logic             arst_n;
    logic             triggerInputPin;
    logic             spiTriggerWrite;
    logic             triggerSourcePin;
    logic             cycleTimeSelect;
    logic [WIN_W-1:0] openCycles;
    logic [WIN_W-1:0] closedCycles;
    logic [ERR_W-1:0] errorThreshold;
    logic             configWrite;
    logic             initTimerExpired;
    logic             resetOutputPin;
    logic             postRegEnable;
    logic             hardResetReq;
    logic             interruptReq;
    logic             windowValid;
    logic             windowInvalid;
    logic             initServiced;
    logic [ERR_W-1:0] errorCount;
    wwdm_state_t      windowState;
    int               failCount = 0;
    int               testsRun  = 0;
    int               vCnt      = 0;
    int               iCnt      = 0;
    int               qCnt      = 0;
    int               hCnt      = 0;
    int               v0, i0, q0, h0, n;

    wwdm_window_watchdog_monitor #(
        .CYC0_CNT   (C0),
        .CYC1_CNT   (C1),
        .SAMPLE_CNT (SMP),
        .RESET_CNT  (RCNT),
        .LOW_CNT    (LCNT)
    ) u_wwdm_window_watchdog_monitor (
        .clk              (clk),
        .arst_n           (arst_n),
        .triggerInputPin  (triggerInputPin),
        .spiTriggerWrite  (spiTriggerWrite),
        .triggerSourcePin (triggerSourcePin),
        .cycleTimeSelect  (cycleTimeSelect),
        .openCycles       (openCycles),
        .closedCycles     (closedCycles),
        .errorThreshold   (errorThreshold),
        .configWrite      (configWrite),
        .initTimerExpired (initTimerExpired),
        .resetOutputPin   (resetOutputPin),
        .postRegEnable    (postRegEnable),
        .hardResetReq     (hardResetReq),
        .interruptReq     (interruptReq),
        .windowValid      (windowValid),
        .windowInvalid    (windowInvalid),
        .initServiced     (initServiced),
        .errorCount       (errorCount),
        .windowState      (windowState)
    );
    wwdm_mcu_model #(.SAMPLE_CNT(SMP)) u_wwdm_mcu_model (
        .clk            (clk),
        .triggerInputPin(triggerInputPin),
        .spiTriggerWrite(spiTriggerWrite)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Pulses are tallied, so none is lost while a task holds the pin
    always @(posedge clk)
    begin
        vCnt <= vCnt + int'(windowValid === 1'b1);
        iCnt <= iCnt + int'(windowInvalid === 1'b1);
        qCnt <= qCnt + int'(interruptReq === 1'b1);
        hCnt <= hCnt + int'(hardResetReq === 1'b1);
    end

    task automatic endOfTest();
        if (failCount == 0 && testsRun > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp);
            failCount++;
        end
    endtask

    task automatic snap();
        v0 = vCnt;
        i0 = iCnt;
        q0 = qCnt;
        h0 = hCnt;
        n  = 0;
    endtask

    task automatic waitEv(input int bound);
        snap();
        while (vCnt + iCnt == v0 + i0 && n < bound)
        begin
            @(negedge clk);
            n++;
        end
        if (vCnt + iCnt == v0 + i0)
        begin
            $display("mismatch t=%0t got=%0h exp=%0h", $time, n, bound);
            failCount++;
            endOfTest();
        end
    endtask

    task automatic waitState(input wwdm_state_t st, input int bound);
        snap();
        while (windowState !== st && n < bound)
        begin
            @(negedge clk);
            n++;
        end
        if (windowState !== st)
        begin
            $display("mismatch t=%0t got=%0h exp=%0h", $time, windowState, st);
            failCount++;
            endOfTest();
        end
    endtask

    task automatic spi();
        u_wwdm_mcu_model.spi_write();
        waitEv(6);
    endtask

    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask

    initial
    begin
        arst_n = 1'b0;
        triggerSourcePin = 1'b0;
        cycleTimeSelect = 1'b0;
        openCycles = 16'h0064;
        closedCycles = 16'h000A;
        errorThreshold = 8'h00;
        configWrite = 1'b0;
        initTimerExpired = 1'b0;
        repeat (3) @(negedge clk);
        chk(windowState, ST_RESET);
        chk(resetOutputPin, 1'b0);
        chk(postRegEnable, 1'b1);
        arst_n = 1'b1;
        waitState(ST_LONG, RCNT + 4);
        chk(resetOutputPin, 1'b1);
        chk(initServiced, 1'b0);
        waitEv(LCNT * C0 + 20);
        chk(n >= LCNT * C0 - C0 && n <= LCNT * C0 + C0 + 2, 1'b1);
        chk(windowState, ST_LONG);
        chk(errorCount, 8'h02);
        cycleTimeSelect = 1'b1;
        waitEv(LCNT * C1 + 40);
        chk(n >= LCNT * C1 - C1 - 4 && n <= LCNT * C1 + C1 + 2, 1'b1);
        spi();
        chk(vCnt - v0, 8'h01);
        chk(windowState, ST_CLOSED);
        chk(errorCount, 8'h03);
        chk(initServiced, 1'b1);
        spi();
        chk(qCnt - q0, 8'h01);
        chk(windowState, ST_OPEN);
        chk(errorCount, 8'h05);
        spi();
        chk(windowState, ST_CLOSED);
        chk(errorCount, 8'h04);
        waitState(ST_OPEN, C1 * 12);
        chk(n >= C1 * 10 - C1 - 2 && n <= C1 * 10 + C1, 1'b1);
        chk(qCnt - q0, 8'h00);
        waitEv(C1 * 100 + 2 * C1);
        chk(n >= C1 * 100 - C1 - 2 && n <= C1 * 100 + C1 + 2, 1'b1);
        chk(iCnt - i0, 8'h01);
        chk(windowState, ST_OPEN);
        chk(errorCount, 8'h06);
        // Pin source: SPI writes and rising edges must pass unseen
        triggerSourcePin = 1'b1;
        pulse(configWrite);
        snap();
        u_wwdm_mcu_model.spi_write();
        u_wwdm_mcu_model.pin_hold(1'b1, 3);
        u_wwdm_mcu_model.pin_set(1'b0);
        repeat (SMP - 2) @(negedge clk);
        u_wwdm_mcu_model.pin_hold(1'b1, 4);
        chk(vCnt + iCnt - v0 - i0, 8'h00);
        u_wwdm_mcu_model.pin_set(1'b0);
        waitEv(4 * SMP + 10);
        // Sync delay plus two sample periods from the falling pin
        chk(n >= 2 * SMP - 1 && n <= 2 * SMP + 5, 1'b1);
        chk(windowState, ST_CLOSED);
        chk(errorCount, 8'h05);
        // High samples in the closed window, low ones in the open window, then both in the closed window
        u_wwdm_mcu_model.pin_hold(1'b1, 3);
        waitState(ST_OPEN, C1 * 12);
        u_wwdm_mcu_model.pin_set(1'b0);
        waitEv(4 * SMP + 10);
        chk(vCnt - v0, 8'h01);
        u_wwdm_mcu_model.pin_hold(1'b1, 3);
        u_wwdm_mcu_model.pin_set(1'b0);
        waitEv(4 * SMP + 10);
        chk(iCnt - i0, 8'h01);
        chk(errorCount, 8'h06);
        // Threshold reached mid-run
        triggerSourcePin = 1'b0;
        errorThreshold = 8'h07;
        pulse(configWrite);
        spi();
        spi();
        chk(windowState, ST_RESET);
        chk(resetOutputPin, 1'b0);
        chk(errorCount, 8'h00);
        chk(initServiced, 1'b0);
        waitState(ST_LONG, RCNT + 4);
        spi();
        chk(errorCount, 8'h00);
        // Second reset, then two unserviced init expiries
        arst_n = 1'b0;
        @(negedge clk);
        chk(windowState, ST_RESET);
        arst_n = 1'b1;
        waitState(ST_LONG, RCNT + 4);
        pulse(initTimerExpired);
        waitState(ST_RESET, 4);
        chk(resetOutputPin, 1'b0);
        chk(postRegEnable, 1'b1);
        waitState(ST_LONG, RCNT + 4);
        chk(resetOutputPin, 1'b1);
        chk(qCnt - q0, 8'h00);
        pulse(initTimerExpired);
        waitState(ST_FAULT, 4);
        repeat (2) @(negedge clk);
        chk(postRegEnable, 1'b0);
        chk(hCnt - h0, 8'h01);
        // Third reset: reconfigure, soft reset, then a silent long window
        arst_n = 1'b0;
        @(negedge clk);
        chk(postRegEnable, 1'b1);
        arst_n = 1'b1;
        waitState(ST_LONG, RCNT + 4);
        pulse(configWrite);
        chk(windowState, ST_OPEN);
        chk(initServiced, 1'b0);
        pulse(initTimerExpired);
        waitState(ST_LONG, RCNT + 8);
        waitState(ST_FAULT, LCNT * C1 + C1 + 4);
        chk(n >= LCNT * C1 - C1 && n <= LCNT * C1 + C1 + 2, 1'b1);
        repeat (2) @(negedge clk);
        chk(hCnt - h0, 8'h01);
        chk(iCnt - i0, 8'h00);
        chk(postRegEnable, 1'b0);
        endOfTest();
    end
endmodule
